// File: logic/hpt_pkg.sv
/*
 * Constants for the headphone pop-removal timing block: register offsets,
 * field positions, reset values, delay tables and the sequencer states.
 * Assumes times are counted in cycles of the internal oscillator.
 */
package hpt_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] ADDR_HP_DRIVERS = 8'h1F; // Driver power bits
   localparam logic [7:0] ADDR_POP_TIMING = 8'h21; // Pop timing control
   localparam logic [7:0] RST_HP_DRIVERS = 8'h04; // Bit 2 resets to one
   localparam logic [7:0] RST_POP_TIMING = 8'h3E; // 0 / 0111 / 11 / 0

   // Field positions
   localparam int BIT_LEFT_ON = 7;  // Left driver power
   localparam int BIT_RIGHT_ON = 6; // Right driver power
   localparam int BIT_DAC_ORDER = 7; // DAC off after amplifiers
   localparam int DLY_MSB = 6;      // Power-on delay code
   localparam int DLY_LSB = 3;
   localparam int STEP_MSB = 2;     // Ramp step code
   localparam int STEP_LSB = 1;
   localparam int BIT_CM_SEL = 0;   // Common-mode source

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int unsigned OSC_KHZ_NOM = 8200; // Nominal oscillator rate
   localparam logic [3:0] GAIN_MAX = 4'hF;     // Last gain step

   // Power-on delay per code, in ns (codes 12 to 15 reserved)
   localparam longint unsigned PWRON_NS [16] = '{
      64'd0, 64'd15300, 64'd153000, 64'd1530000, 64'd15300000,
      64'd76200000, 64'd153000000, 64'd304000000, 64'd610000000,
      64'd1220000000, 64'd3040000000, 64'd6100000000,
      64'd6100000000, 64'd6100000000, 64'd6100000000, 64'd6100000000};
   // Ramp step interval per code, in ns
   localparam longint unsigned STEP_NS [4] = '{
      64'd0, 64'd980000, 64'd1950000, 64'd3900000};

   // Oscillator cycles for a time, rounded up
   function automatic logic [31:0] osc_cycles(input longint unsigned t_ns,
                                              input int unsigned osc_khz);
      longint unsigned prod;
      prod = (t_ns * 64'(osc_khz) + 64'd999999) / 64'd1000000;
      return prod[31:0];
   endfunction : osc_cycles

   // ****************************************************************
   // Sequencer states
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,  // Drivers off
      ST_DELAY = 2'h1, // Power-on delay
      ST_RAMP = 2'h2,  // Stepped gain ramp
      ST_ON = 2'h3     // Fully on
   } hpt_state_t;

endpackage : hpt_pkg

// File: logic/hpt_pop_timing.sv
/*
 * Headphone driver pop-removal sequencer with its two control registers.
 * Assumes a 10 MHz system clock, an oscillator pin slower than half of
 * it, and a simple register port (address, write strobe, data).
 */
`timescale 1ns/1ps

module hpt_pop_timing #(
   parameter int unsigned P_OSC_KHZ = hpt_pkg::OSC_KHZ_NOM // Cycles per ms
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_osc,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_dac_request,
   input wire logic i_spk_amp_on,
   output logic [7:0] o_reg_rdata,
   output logic o_left_headphone_driver_on,
   output logic o_right_headphone_driver_on,
   output logic [3:0] o_gain_step,
   output logic o_ramp_done,
   output logic o_dac_on,
   output logic o_cm_weak_en
);

   // ****************************************************************
   // Oscillator synchroniser and tick
   // ****************************************************************
   logic osc_s1; // First stage, read by osc_s2 only
   logic osc_s2; // Second stage
   logic osc_s3; // Edge history
   logic tick;   // One oscillator cycle elapsed

   // Three flops; only the later two feed the edge
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         osc_s1 <= 1'b0;
         osc_s2 <= 1'b0;
         osc_s3 <= 1'b0;
      end else begin
         osc_s1 <= i_osc;
         osc_s2 <= osc_s1;
         osc_s3 <= osc_s2;
      end
   end

   assign tick = osc_s2 & ~osc_s3;

   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [7:0] drv_reg;      // Driver power register
   logic [7:0] pop_reg;      // Pop timing register
   logic [7:0] next_drv_reg;
   logic [7:0] next_pop_reg;
   logic [7:0] next_rdata;

   // Write decode and read mux
   always_comb begin
      next_drv_reg = drv_reg;
      next_pop_reg = pop_reg;
      if (i_reg_wr && i_reg_addr == hpt_pkg::ADDR_HP_DRIVERS) begin
         next_drv_reg = i_reg_wdata;
      end
      if (i_reg_wr && i_reg_addr == hpt_pkg::ADDR_POP_TIMING) begin
         next_pop_reg = i_reg_wdata; // Reserved codes stored as written
      end
      unique case (i_reg_addr)
         hpt_pkg::ADDR_HP_DRIVERS: next_rdata = drv_reg;
         hpt_pkg::ADDR_POP_TIMING: next_rdata = pop_reg;
         default: next_rdata = 8'h00; // Unmapped reads zero
      endcase
   end

   // Register state
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         drv_reg <= hpt_pkg::RST_HP_DRIVERS;
         pop_reg <= hpt_pkg::RST_POP_TIMING;
         o_reg_rdata <= 8'h00;
      end else begin
         drv_reg <= next_drv_reg;
         pop_reg <= next_pop_reg;
         o_reg_rdata <= next_rdata;
      end
   end

   // ****************************************************************
   // Power-on sequencer
   // ****************************************************************
   hpt_pkg::hpt_state_t state;      // Sequencer state
   hpt_pkg::hpt_state_t next_state;
   logic [31:0] cnt;                // Oscillator cycles left
   logic [31:0] next_cnt;
   logic [3:0] next_gain;
   logic any_on;                    // Some driver requested on
   logic [31:0] dly_cycles;         // Selected power-on delay
   logic [31:0] step_cycles;        // Selected step interval

   assign any_on = drv_reg[hpt_pkg::BIT_LEFT_ON] | drv_reg[hpt_pkg::BIT_RIGHT_ON];
   assign dly_cycles = hpt_pkg::osc_cycles(
      hpt_pkg::PWRON_NS[pop_reg[hpt_pkg::DLY_MSB:hpt_pkg::DLY_LSB]], P_OSC_KHZ);
   assign step_cycles = hpt_pkg::osc_cycles(
      hpt_pkg::STEP_NS[pop_reg[hpt_pkg::STEP_MSB:hpt_pkg::STEP_LSB]], P_OSC_KHZ);

   // Next state, counter and gain
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_gain = o_gain_step;
      if (!any_on) begin
         // Both drivers off: drop at once
         next_state = hpt_pkg::ST_IDLE;
         next_cnt = 32'h0000_0000;
         next_gain = 4'h0;
      end else begin
         unique case (state)
            hpt_pkg::ST_IDLE: begin
               next_state = hpt_pkg::ST_DELAY;
               next_cnt = dly_cycles;
            end
            hpt_pkg::ST_DELAY: begin
               if (cnt == 32'h0000_0000) begin
                  next_state = hpt_pkg::ST_RAMP;
                  next_cnt = step_cycles;
               end else if (tick) begin
                  next_cnt = cnt - 32'h0000_0001;
               end
            end
            hpt_pkg::ST_RAMP: begin
               if (cnt == 32'h0000_0000) begin
                  next_gain = o_gain_step + 4'h1;
                  next_cnt = step_cycles;
                  if (o_gain_step == hpt_pkg::GAIN_MAX - 4'h1) begin
                     next_state = hpt_pkg::ST_ON;
                  end
               end else if (tick) begin
                  next_cnt = cnt - 32'h0000_0001;
               end
            end
            hpt_pkg::ST_ON: begin
               next_gain = hpt_pkg::GAIN_MAX;
            end
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= hpt_pkg::ST_IDLE;
         cnt <= 32'h0000_0000;
         o_gain_step <= 4'h0;
         o_ramp_done <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         o_gain_step <= next_gain;
         o_ramp_done <= (next_state == hpt_pkg::ST_ON);
      end
   end

   // ****************************************************************
   // Driver, DAC and common-mode outputs
   // ****************************************************************
   logic next_dac_on;
   logic amps_off; // Headphone and speaker amplifiers fully off

   assign amps_off = (state == hpt_pkg::ST_IDLE) && !o_left_headphone_driver_on
                     && !o_right_headphone_driver_on && !i_spk_amp_on;

   // DAC power-down ordering
   always_comb begin
      next_dac_on = o_dac_on;
      if (i_dac_request) begin
         next_dac_on = 1'b1;
      end else if (!pop_reg[hpt_pkg::BIT_DAC_ORDER]) begin
         next_dac_on = 1'b0;
      end else if (amps_off) begin
         next_dac_on = 1'b0;
      end
   end

   // Output flops
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_left_headphone_driver_on <= 1'b0;
         o_right_headphone_driver_on <= 1'b0;
         o_dac_on <= 1'b0;
         o_cm_weak_en <= 1'b1;
      end else begin
         o_left_headphone_driver_on <= drv_reg[hpt_pkg::BIT_LEFT_ON];
         o_right_headphone_driver_on <= drv_reg[hpt_pkg::BIT_RIGHT_ON];
         o_dac_on <= next_dac_on;
         o_cm_weak_en <= !pop_reg[hpt_pkg::BIT_CM_SEL];
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   a_dac_same_time: assert property (
      !i_dac_request && !pop_reg[hpt_pkg::BIT_DAC_ORDER] |=> !o_dac_on)
      else $error("DAC stayed on with order bit clear");
   a_dac_waits_amps: assert property (
      o_dac_on && !i_dac_request && pop_reg[hpt_pkg::BIT_DAC_ORDER] && !amps_off
      |=> o_dac_on)
      else $error("DAC dropped before amplifiers were off");
   a_zero_delay_code: assert property (
      state == hpt_pkg::ST_IDLE && any_on && dly_cycles == 32'h0000_0000
      ##1 any_on |=> state == hpt_pkg::ST_RAMP)
      else $error("Zero delay code did not reach ramp");
   a_delay_holds_tick: assert property (
      state == hpt_pkg::ST_DELAY && any_on && !tick && cnt != 32'h0000_0000
      |=> cnt == $past(cnt))
      else $error("Delay counted without oscillator tick");
   a_cm_weak_level: assert property (
      !pop_reg[hpt_pkg::BIT_CM_SEL] ##1 !$past(pop_reg[hpt_pkg::BIT_CM_SEL])
      |-> o_cm_weak_en)
      else $error("Weak common-mode not enabled");
   a_driver_starts: assert property (
      state == hpt_pkg::ST_IDLE && drv_reg[hpt_pkg::BIT_LEFT_ON]
      |=> o_left_headphone_driver_on && state == hpt_pkg::ST_DELAY)
      else $error("Left driver request did not start sequence");
   a_ramp_after_delay: assert property (
      state == hpt_pkg::ST_RAMP |-> $past(state) inside {hpt_pkg::ST_DELAY, hpt_pkg::ST_RAMP})
      else $error("Ramp entered without power-on delay");
   a_gain_in_ramp: assert property (
      o_gain_step != $past(o_gain_step) && o_gain_step != 4'h0
      |-> $past(state) == hpt_pkg::ST_RAMP)
      else $error("Gain stepped outside ramp");
   a_reset_fields: assert property (
      $rose(i_reset_n) |-> pop_reg == hpt_pkg::RST_POP_TIMING)
      else $error("Pop timing register reset value wrong");

   c_full_ramp: cover property (state == hpt_pkg::ST_RAMP ##1 state == hpt_pkg::ST_ON);
   c_dac_delayed: cover property (o_dac_on && !i_dac_request && !amps_off
                                  && pop_reg[hpt_pkg::BIT_DAC_ORDER]);
   c_abort_delay: cover property (state == hpt_pkg::ST_DELAY ##1 state == hpt_pkg::ST_IDLE);
   c_both_drivers: cover property (o_left_headphone_driver_on && o_right_headphone_driver_on);

endmodule : hpt_pop_timing

// File: verif/hpt_pop_timing_tb.sv
/*
 * Self-checking bench for the pop-removal sequencer: registers, ramp timing, DAC order.
 * Assumes hpt_pkg is compiled first; the design carries its own assertions.
 */
`timescale 1ns/1ps
module hpt_pop_timing_tb;
   // ************************************************************
   // Signals and bookkeeping
   // ************************************************************
   localparam int unsigned OSC_KHZ = 10; // Short counts for simulation
   logic clk, reset_n, osc, reg_wr, dac_request, spk_amp_on;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic left_on, right_on, ramp_done, dac_on, cm_weak_en;
   logic [3:0] gain_step;
   typedef struct {string name; int kind; logic [7:0] exp; int due;} hpt_note_t;
   hpt_note_t q[$]; // Expected results, oldest first
   int cyc = 0;     // Rising edges seen
   int failures = 0;
   int n_tests = 0;

   hpt_pop_timing #(.P_OSC_KHZ(OSC_KHZ)) dut_u (
      .i_clk(clk), .i_reset_n(reset_n), .i_osc(osc), .i_reg_wr(reg_wr),
      .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_dac_request(dac_request),
      .i_spk_amp_on(spk_amp_on), .o_reg_rdata(reg_rdata),
      .o_left_headphone_driver_on(left_on), .o_right_headphone_driver_on(right_on),
      .o_gain_step(gain_step), .o_ramp_done(ramp_done), .o_dac_on(dac_on),
      .o_cm_weak_en(cm_weak_en));

   // ************************************************************
   // Clocks: 10 MHz system, 1 MHz oscillator of unrelated phase
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      osc = 1'b0;
      #137;
      forever #500 osc = ~osc;
   end

   // ************************************************************
   // Helpers
   // ************************************************************
   // Compare and count
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Output picked by a note
   function automatic logic [7:0] sel(input int kind);
      case (kind)
         0: return reg_rdata;
         1: return {4'h0, gain_step};
         2: return {7'h0, dac_on};
         3: return {6'h0, left_on, right_on};
         4: return {7'h0, ramp_done};
         default: return {7'h0, cm_weak_en};
      endcase
   endfunction : sel

   // Oscillator counts for a time, rounded up
   function automatic int ocnt(input longint unsigned t_ns);
      return int'((t_ns * OSC_KHZ + 64'd999999) / 64'd1000000);
   endfunction : ocnt

   task automatic note(input string nm, input int k, input logic [7:0] e, input int lat);
      q.push_back('{nm, k, e, cyc + lat});
   endtask : note

   // One register write, strobe held over one rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : wr

   // Read data shows one edge after the address is set; the next task may move it
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      @(negedge clk);
      reg_addr = a;
      note(nm, 0, e, 1);
   endtask : rd

   task automatic report_and_stop;
      $display("comparisons %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop

   // Power both drivers, time the whole sequence, then power down
   task automatic run(input int d, input int s);
      int c;
      int n;
      c = ocnt(hpt_pkg::PWRON_NS[d]) + 15 * ocnt(hpt_pkg::STEP_NS[s]);
      wr(8'h21, {1'b0, 4'(d), 2'(s), 1'b0});
      wr(8'h1F, 8'hC4);
      note("drivers on", 3, 8'h03, 1);
      n = 0;
      while (ramp_done !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 20000) begin
         failures++;
         report_and_stop();
      end
      chk("ramp time", 8'(n >= c * 10 - 10 && n <= c * 10 + 200), 8'h01);
      note("top gain", 1, 8'h0F, 1);
      note("ramp done", 4, 8'h01, 1);
      wr(8'h1F, 8'h04);
      note("drivers off", 3, 8'h00, 1);
      note("gain cleared", 1, 8'h00, 3);
      note("ramp cleared", 4, 8'h00, 3);
   endtask : run

   // ************************************************************
   // Monitor: takes due notes off the queue after each edge
   // ************************************************************
   always @(posedge clk) begin : mon_p
      hpt_note_t n;
      #1;
      cyc++;
      while (q.size() > 0 && q[0].due <= cyc) begin
         n = q.pop_front();
         chk(n.name, sel(n.kind), n.exp);
      end
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin : main_p
      logic [7:0] rv;
      logic [7:0] a;
      int n;
      reset_n = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      dac_request = 1'b1;
      spk_amp_on = 1'b1;
      void'($urandom(56880));
      // Four rising edges inside reset, release off the edge
      repeat (4) @(negedge clk);
      reset_n = 1'b1;
      note("cm weak", 5, 8'h01, 1);
      rd(8'h21, 8'h3E, "timing reset");
      // Random legal value: no reserved delay code, cm bit kept 0
      rv = 8'($urandom);
      rv[6:3] = 4'(rv[6:3] % 4'hC);
      rv[0] = 1'b0;
      wr(8'h21, rv);
      rd(8'h21, rv, "timing rw");
      a = 8'($urandom);
      if (a == 8'h1F || a == 8'h21) begin
         a = 8'h22;
      end
      wr(a, 8'hFF);
      rd(a, 8'h00, "unmapped");
      rd(8'h21, rv, "timing kept");
      // Cycle-exact walk, zero delay and zero step
      wr(8'h21, 8'h00);
      wr(8'h1F, 8'h84);
      note("left only", 3, 8'h02, 1);
      for (int k = 1; k <= 15; k++) begin
         note("gain walk", 1, 8'(k), 2 + k);
      end
      repeat (20) @(negedge clk);
      wr(8'h1F, 8'h04);
      for (int d = 0; d <= 5; d++) begin
         run(d, 0);
      end
      for (int s = 1; s <= 3; s++) begin
         run(1, s);
      end
      // Order bit 0: DAC drops at once, speaker amplifier still on
      wr(8'h21, 8'h00);
      @(negedge clk);
      dac_request = 1'b0;
      note("dac with amps", 2, 8'h00, 1);
      @(negedge clk);
      dac_request = 1'b1;
      note("dac back", 2, 8'h01, 1);
      // Order bit 1: DAC waits for drivers and speaker
      wr(8'h21, 8'h80);
      wr(8'h1F, 8'hC4);
      @(negedge clk);
      dac_request = 1'b0;
      note("dac held spk", 2, 8'h01, 6);
      repeat (8) @(negedge clk);
      spk_amp_on = 1'b0;
      note("dac held hp", 2, 8'h01, 4);
      repeat (6) @(negedge clk);
      wr(8'h1F, 8'h04);
      n = 0;
      while (dac_on !== 1'b0 && n < 8) begin
         @(negedge clk);
         n++;
      end
      // Drivers drop one edge after the write, the DAC one edge after them
      chk("dac after amps", 8'(n >= 2 && n < 8), 8'h01);
      repeat (5) @(negedge clk);
      report_and_stop();
   end
endmodule : hpt_pop_timing_tb
